// >>> hdl/tws_pkg.sv
// Shared constants, states and pin carriers for the two-wire SAR sequencer.
// Assumes a 200 MHz system clock and open-drain bus pads outside the block.
package tws_pkg;
	// ==================================================================
	// Clocking
	localparam int         CLK_HZ    = 200_000_000;
	localparam int         OSC_HZ    = 4_000_000;
	localparam int         OSC_DIV   = CLK_HZ / OSC_HZ;
	localparam logic [5:0] OSC_LAST  = 6'(OSC_DIV - 1);
	localparam logic [5:0] OSC_RESET = 6'h00;
	// ==================================================================
	// Address and result format
	localparam logic [2:0]  ADDR_FIXED  = 3'h3;
	localparam logic [1:0]  SUB_BITS    = 2'h0;
	localparam logic [13:0] DAC_MSB     = 14'h2000;
	localparam logic [13:0] DAC_RESET   = 14'h0000;
	localparam logic [3:0]  SAR_MSB_IDX = 4'hD;
	localparam logic [15:0] OUT_RESET   = 16'h0000;
	// ==================================================================
	// Bit counter positions
	localparam logic [3:0] BIT_ZERO  = 4'h0;
	localparam logic [3:0] BIT_TRACK = 4'h7;
	localparam logic [3:0] BIT_ADDR  = 4'h8;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_TX_TR = 4'h6;
	// ==================================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_CONV,
		ST_TX,
		ST_ACK_RX
	} tws_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} tws_line_s;
endpackage

// >>> hdl/tws_sequencer.sv
// Two-wire slave and SAR sequencer for a 14-bit converter.
// Assumes open-drain pads resolved outside; the comparator, straps and
// bus lines are asynchronous and are synchronised here.
`timescale 1ns/100ps

// Function
// R1: Straps give the low four address bits.
// R2: Tied trim node forces external reference mode.
// R3: Each conversion yields fourteen bits, sent serially.
// R4: Free-running 4MHz tick drives SAR steps.
// R5: Reset leaves the device shut down.
// R6: Track during the two clocks before conversion.
// R7: Hold except acquisition; hold during conversion.
// R8: Pull clock line low while converting.
// R9: Keep result internally; master reads after release.
// R10: Master starts transfers and drives the clock.
// R11: Upper address bits fixed at 011.
// R12: Convert right after acknowledging our address.
// R13: Two bytes, MSB first, repeat on acknowledge.
// R14: Not-acknowledge with write bit clears internal reference.
// R15: Result register stays stable until shifted out.
module tws_sequencer (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire tws_pkg::tws_line_s bus_i,
	output tws_pkg::tws_line_s     bus_o,
	output tws_pkg::tws_line_s     bus_oe_o,
	input  wire logic [3:0]        addr_strap_i,
	input  wire logic              bandgap_trim_node_i,
	input  wire logic              comp_i,
	output logic                   th_track_o,
	output logic                   adc_powered_o,
	output logic                   ref_enable_o,
	output logic                   ref_buf_enable_o,
	output logic [13:0]            dac_code_o
);
	import tws_pkg::*;

	// ==================================================================
	// Synchronisers
	logic [7:0]  meta_reg, sync_reg, shin_reg;
	logic        scl_d_reg, sda_d_reg, byte_sel_reg, rw_reg, ack_reg;
	logic        sda_oe_reg, scl_oe_reg, track_reg, ref_on_reg;
	tws_state_e  state_reg;
	logic [3:0]  bitcnt_reg, sar_idx_reg;
	logic [5:0]  osc_cnt_reg;
	logic [13:0] dac_reg;
	logic [15:0] out_reg;
	// Only the second stage is ever read
	always_ff @(posedge mclk_i) begin
		meta_reg <= {comp_i, bandgap_trim_node_i, addr_strap_i, bus_i.sda, bus_i.scl};
		sync_reg <= meta_reg;
	end
	wire       scl_s   = sync_reg[0];
	wire       sda_s   = sync_reg[1];
	wire [3:0] strap_s = sync_reg[5:2];
	wire       ext_s   = sync_reg[6];
	wire       comp_s  = sync_reg[7];
	// Edge history of the synchronised lines
	always_ff @(posedge mclk_i) begin
		scl_d_reg <= scl_s;
		sda_d_reg <= sda_s;
	end
	// ==================================================================
	// Bus events and decode
	// Bus events follow the master's clock edges
	wire scl_rise  = scl_s & ~scl_d_reg; // R10
	wire scl_fall  = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	// Address compare: fixed upper bits, strap lower bits
	wire hit7 = (shin_reg[6:0] == {ADDR_FIXED, strap_s}); // R11
	wire hit8 = (shin_reg[7:1] == {ADDR_FIXED, strap_s}); // R1
	wire [3:0] bitcnt_p1 = bitcnt_reg + 4'h1;
	wire [3:0] tx_idx    = {byte_sel_reg, bitcnt_reg[2:0]};
	wire [3:0] tx_nidx   = {byte_sel_reg, bitcnt_p1[2:0]};
	// Index by complement walks the word from bit 15 down
	wire tx_next_bit = out_reg[~tx_nidx]; // R13
	// ==================================================================
	// Conversion clock and SAR step
	// Free divider, independent of the bus clock
	wire osc_tick = (osc_cnt_reg == OSC_LAST); // R4
	always_ff @(posedge mclk_i) begin
		if (rst_i || osc_tick) begin
			osc_cnt_reg <= OSC_RESET;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 6'h01;
		end
	end
	wire [13:0] sar_mask  = 14'h0001 << sar_idx_reg;
	wire [13:0] sar_keep  = comp_s ? dac_reg : (dac_reg & ~sar_mask);
	wire [13:0] dac_next  = sar_keep | (sar_mask >> 1);
	wire        conv_last = (state_reg == ST_CONV) && osc_tick && (sar_idx_reg == BIT_ZERO);
	// ==================================================================
	// Sequencer
	// Start and stop override the case; both need SCL high, so neither
	// can land during conversion while SCL is held low.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg    <= ST_IDLE; // R5
			bitcnt_reg   <= BIT_ZERO;
			shin_reg     <= 8'h00;
			byte_sel_reg <= 1'b0;
			rw_reg       <= 1'b0;
			ack_reg      <= 1'b0;
			sda_oe_reg   <= 1'b0;
			scl_oe_reg   <= 1'b0;
			track_reg    <= 1'b0;
			ref_on_reg   <= 1'b0; // R5
			sar_idx_reg  <= SAR_MSB_IDX;
			dac_reg      <= DAC_RESET;
			out_reg      <= OUT_RESET;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (scl_rise) begin
						shin_reg   <= {shin_reg[6:0], sda_s};
						bitcnt_reg <= bitcnt_p1;
					end
					if (scl_fall && bitcnt_reg == BIT_TRACK && hit7) begin
						track_reg <= 1'b1; // R6
					end
					if (scl_fall && bitcnt_reg == BIT_ADDR) begin
						if (hit8) begin
							sda_oe_reg <= 1'b1;
							rw_reg     <= shin_reg[0];
							state_reg  <= ST_ACK_ADDR;
						end else begin
							track_reg <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						sda_oe_reg  <= 1'b0;
						track_reg   <= 1'b0; // R7
						scl_oe_reg  <= 1'b1; // R8
						ref_on_reg  <= 1'b1;
						dac_reg     <= DAC_MSB;
						sar_idx_reg <= SAR_MSB_IDX;
						state_reg   <= ST_CONV; // R12
					end
				end
				ST_CONV: begin
					if (osc_tick) begin
						dac_reg     <= dac_next;
						sar_idx_reg <= sar_idx_reg - 4'h1;
					end
					// Result is loaded only here, then left alone
					if (conv_last) begin
						out_reg      <= {sar_keep, SUB_BITS}; // R3 R15
						scl_oe_reg   <= 1'b0; // R9
						sda_oe_reg   <= ~sar_keep[13];
						bitcnt_reg   <= BIT_ZERO;
						byte_sel_reg <= 1'b0;
						state_reg    <= ST_TX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (byte_sel_reg && bitcnt_reg == BIT_TX_TR) begin
							track_reg <= 1'b1; // R6
						end
						if (bitcnt_reg == BIT_LAST) begin
							sda_oe_reg <= 1'b0;
							state_reg  <= ST_ACK_RX;
						end else begin
							sda_oe_reg <= ~tx_next_bit; // R13
							bitcnt_reg <= bitcnt_p1;
						end
					end
				end
				ST_ACK_RX: begin
					if (scl_rise) begin
						ack_reg <= ~sda_s;
					end
					if (scl_fall) begin
						if (ack_reg && !byte_sel_reg) begin
							byte_sel_reg <= 1'b1;
							bitcnt_reg   <= BIT_ZERO;
							sda_oe_reg   <= ~out_reg[7];
							state_reg    <= ST_TX;
						end else if (ack_reg) begin
							track_reg   <= 1'b0; // R7
							scl_oe_reg  <= 1'b1; // R8
							dac_reg     <= DAC_MSB;
							sar_idx_reg <= SAR_MSB_IDX;
							state_reg   <= ST_CONV; // R13
						end else begin
							track_reg <= 1'b0;
							state_reg <= ST_IDLE;
							if (!ext_s && !rw_reg) begin
								ref_on_reg <= 1'b0; // R14
							end
						end
					end
				end
				default: begin
				end
			endcase
			if (start_det) begin
				state_reg  <= ST_ADDR;
				bitcnt_reg <= BIT_ZERO;
				shin_reg   <= 8'h00;
				sda_oe_reg <= 1'b0;
				track_reg  <= 1'b0;
			end else if (stop_det) begin
				state_reg  <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				track_reg  <= 1'b0;
			end
		end
	end
	// ==================================================================
	// Outputs
	// Open drain: the pads only ever pull low
	assign bus_o            = '0;
	assign bus_oe_o         = '{scl: scl_oe_reg, sda: sda_oe_reg};
	assign th_track_o       = track_reg;
	assign adc_powered_o    = track_reg | (state_reg == ST_CONV);
	// Tied trim node turns bandgap and buffer off
	assign ref_enable_o     = ref_on_reg & ~ext_s; // R2
	assign ref_buf_enable_o = ref_on_reg & ~ext_s; // R2
	assign dac_code_o       = dac_reg;
	// ==================================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_conv_start;
		(state_reg == ST_ACK_ADDR) && scl_fall;
	endsequence
	sequence s_stretch;
		scl_oe_reg [*8];
	endsequence
	property p_addr_hit;
		(state_reg == ST_ADDR) && scl_fall && (bitcnt_reg == BIT_ADDR) && hit8
			|=> (state_reg == ST_ACK_ADDR) && sda_oe_reg;
	endproperty
	a_addr_hit: assert property (p_addr_hit) else $error("own address not acknowledged"); // R1
	property p_ext_ref;
		ext_s |-> !ref_enable_o && !ref_buf_enable_o;
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("reference on in external mode"); // R2
	property p_result_load;
		conv_last |=> (out_reg[15:2] == $past(sar_keep)) && (out_reg[1:0] == SUB_BITS)
			&& (state_reg == ST_TX) && (sda_oe_reg == ~out_reg[15]);
	endproperty
	a_result_load: assert property (p_result_load) else $error("bad result load"); // R3
	property p_osc_period;
		osc_tick |-> ##1 !osc_tick [*8] ##41 !osc_tick ##1 osc_tick;
	endproperty
	a_osc_period: assert property (p_osc_period) else $error("oscillator tick spacing wrong"); // R4
	property p_reset_off;
		$fell(rst_i) |-> (state_reg == ST_IDLE) && !ref_on_reg && !adc_powered_o && !scl_oe_reg;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("not shut down after reset"); // R5
	property p_track_rise;
		$rose(track_reg) |-> $past(scl_fall) && ($past(state_reg) inside {ST_ADDR, ST_TX});
	endproperty
	a_track_rise: assert property (p_track_rise) else $error("track started off an edge"); // R6
	property p_hold_conv;
		(state_reg == ST_CONV) |-> !th_track_o;
	endproperty
	a_hold_conv: assert property (p_hold_conv) else $error("tracking during conversion"); // R7
	property p_stretch;
		s_conv_start |=> s_stretch;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not stretched"); // R8
	property p_conv_low;
		(state_reg == ST_CONV) |-> scl_oe_reg && $stable(out_reg);
	endproperty
	a_conv_low: assert property (p_conv_low) else $error("clock or result moved in conversion"); // R9
	property p_addr_miss;
		(state_reg == ST_ADDR) && scl_fall && (bitcnt_reg == BIT_ADDR)
			&& (shin_reg[7:5] != ADDR_FIXED) |=> (state_reg == ST_IDLE) && !sda_oe_reg;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered"); // R11
	property p_go_conv;
		s_conv_start |=> (state_reg == ST_CONV) && (dac_reg == DAC_MSB) && !track_reg;
	endproperty
	a_go_conv: assert property (p_go_conv) else $error("conversion did not start"); // R12
	property p_tx_bit;
		(state_reg == ST_TX) |-> (sda_oe_reg == ~out_reg[~tx_idx]);
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("wrong data bit on line"); // R13
	property p_nack_ref;
		(state_reg == ST_ACK_RX) && scl_fall && !ack_reg && !rw_reg && !ext_s
			|=> !ref_on_reg && (state_reg == ST_IDLE);
	endproperty
	a_nack_ref: assert property (p_nack_ref) else $error("reference not shut down"); // R14
	property p_out_stable;
		!conv_last |=> $stable(out_reg);
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("result changed before readout"); // R15
endmodule // tws_sequencer

// >>> tb/tws_master_model.sv
// Bus master model for the two-wire port: makes the link clock, sends bits.
// Assumes pull-ups on both lines, resolved by the bench, and the 200 MHz clock.
`timescale 1ns/100ps
module tws_master_model (
	input  wire logic mclk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	int stretch_cnt;

	// Both lines released at start, so the pull-ups hold them idle high
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	// ==================================================================
	// Link phases: 8 clocks high and at least 8 low make an 80 ns period
	task automatic half();
		repeat (8) @(negedge mclk_i);
	endtask

	// One bit: data moves a few clocks after the fall, so it never looks like
	// a start or stop; the wait for a stretched clock is bounded
	task automatic bit_io(input logic b, output logic r);
		repeat (4) @(negedge mclk_i);
		sda_low_o = ~b;
		repeat (4) @(negedge mclk_i);
		scl_low_o = 1'b0;
		stretch_cnt = 0;
		// Look one edge later, once the released line has settled
		@(negedge mclk_i);
		while (scl_i !== 1'b1 && stretch_cnt < 2000) begin
			@(negedge mclk_i);
			stretch_cnt++;
		end
		repeat (7) @(negedge mclk_i);
		r = sda_i;
		scl_low_o = 1'b1;
	endtask

	// Start: data falls while the clock is high
	task automatic start();
		sda_low_o = 1'b1;
		half();
		scl_low_o = 1'b1;
	endtask

	// Stop: data rises while the clock is high, then the bus is free
	task automatic stop();
		repeat (4) @(negedge mclk_i);
		sda_low_o = 1'b1;
		half();
		scl_low_o = 1'b0;
		half();
		sda_low_o = 1'b0;
		half();
	endtask
endmodule // tws_master_model

// >>> tb/test_two_wire_sar_adc_sequencer.sv
// Self-checking bench for the two-wire SAR sequencer.
// Assumes tws_pkg and tws_master_model; the comparator is an ideal model.
`timescale 1ns/100ps
module test_two_wire_sar_adc_sequencer;
	import tws_pkg::*;
	logic        mclk, rst, trim, track, powered, ref_en, ref_buf, comp, m_scl, m_sda;
	tws_line_s   bus_in, bus_out, bus_oe;
	logic [3:0]  strap;
	logic [13:0] dac, ain;
	int          num_errors, total_checks, track_edges, track_bad;

	tws_sequencer dut_u (.mclk_i(mclk), .rst_i(rst), .bus_i(bus_in), .bus_o(bus_out),
		.bus_oe_o(bus_oe), .addr_strap_i(strap), .bandgap_trim_node_i(trim), .comp_i(comp),
		.th_track_o(track), .adc_powered_o(powered), .ref_enable_o(ref_en),
		.ref_buf_enable_o(ref_buf), .dac_code_o(dac));
	tws_master_model mdl_u (.mclk_i(mclk), .scl_i(bus_in.scl), .sda_i(bus_in.sda),
		.scl_low_o(m_scl), .sda_low_o(m_sda));

	// Wired-AND lines with pull-ups, and a comparator that keeps a bit when ain >= code
	assign bus_in = '{scl: ~(m_scl | bus_oe.scl), sda: ~(m_sda | bus_oe.sda)};
	assign comp = (ain >= dac);

	// ==================================================================
	// Clock, and watchers of the track switch against the link clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge bus_in.scl) if (track === 1'b1) track_edges++;
	always @(posedge mclk) if (bus_oe.scl === 1'b1 && track !== 1'b0) track_bad++;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	task automatic addr_phase(input logic [7:0] a, output logic ack_n);
		logic r;
		mdl_u.start();
		for (int i = 0; i < 8; i++) mdl_u.bit_io(a[7-i], r);
		mdl_u.bit_io(1'b1, ack_n);
	endtask

	// Foreign addresses: no acknowledge, nothing powers up
	task automatic wrong_addr(input logic [3:0] st, input logic [7:0] a);
		logic r;
		@(negedge mclk);
		strap = st;
		repeat (4) @(negedge mclk);
		addr_phase(a, r);
		check("foreign_ack", r, 1'b1);
		check("foreign_power", powered, 1'b0);
		mdl_u.stop();
	endtask

	// Reads of one or more results; the last word is refused to end the run
	task automatic read_conv(input logic [3:0] st, input logic rw, input logic ext,
		input logic [13:0] a, input int words);
		logic        r;
		logic [15:0] w;
		@(negedge mclk);
		strap = st;
		trim = ext;
		ain = a;
		repeat (4) @(negedge mclk);
		track_edges = 0;
		addr_phase({3'b011, st, rw}, r);
		check("addr_ack", r, 1'b0);
		// Just past the ninth fall the core converts with the clock held
		repeat (4) @(negedge mclk);
		check("powered_conv", powered, 1'b1);
		check("stretch_on", bus_oe.scl, 1'b1);
		check("hold_conv", track, 1'b0);
		check("ref_conv", ref_en, !ext);
		for (int k = 0; k < words; k++) begin
			for (int i = 0; i < 16; i++) begin
				if (i == 8) track_edges = 0;
				mdl_u.bit_io(1'b1, w[15-i]);
				if (i == 0) check("stretch", 16'(mdl_u.stretch_cnt >= 600 && mdl_u.stretch_cnt <= 720), 1);
				if (i == 0) check("track_cycles", 16'(track_edges), 2);
				if (i == 7) mdl_u.bit_io(1'b0, r);
			end
			check("word", w, {a, 2'b00});
			mdl_u.bit_io(k == words - 1, r);
		end
		mdl_u.stop();
		check("ref_on", ref_en, ~ext & rw);
		check("ref_buf_on", ref_buf, ~ext & rw);
		check("dac_final", dac, a);
		check("powered_idle", powered, 1'b0);
	endtask

	// ==================================================================
	// Main sequence: reset held two cycles, then every scenario in turn
	initial begin
		rst = 1'b1;
		trim = 1'b0;
		strap = 4'h0;
		ain = 14'h0000;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (6) @(negedge mclk);
		check("oe_reset", 16'(bus_oe), 16'h0000);
		check("pad_value", 16'(bus_out), 16'h0000);
		check("track_reset", track, 1'b0);
		check("power_reset", {powered, ref_en, ref_buf}, 3'h0);
		check("dac_reset", dac, 14'h0000);
		read_conv(4'hA, 1'b1, 1'b0, 14'h2A5C, 2);
		read_conv(4'h5, 1'b0, 1'b0, 14'h3FFF, 1);
		read_conv(4'h0, 1'b1, 1'b1, 14'h0001, 1);
		wrong_addr(4'h6, 8'h73);
		wrong_addr(4'h6, 8'hED);
		check("track_in_conv", 16'(track_bad), 16'h0000);
		end_sim();
	end

	// Watchdog: the run needs well under 50 us
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
endmodule // test_two_wire_sar_adc_sequencer
